// ===== rtl/ida_top.v
/*
 * Indirect data addressing: two pointer channels with post step,
 * bank selection, table pointer and latch, mode access decode,
 * AXI4-Lite register slave.
 * Assumes core, data memory and program memory share aclk; data
 * memory read data is valid in the cycle mem_en is high.
 */
`timescale 1ns/1ps
`include "ida_defs.vh"

module ida_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_awaddr,
  input  wire [2:0]  s_awprot,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  output wire [1:0]  s_bresp,
  output wire        s_bvalid,
  input  wire        s_bready,
  input  wire [7:0]  s_araddr,
  input  wire [2:0]  s_arprot,
  input  wire        s_arvalid,
  output wire        s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0]  s_rresp,
  output wire        s_rvalid,
  input  wire        s_rready,
  input  wire        acc_valid,
  input  wire        acc_ch,
  input  wire        acc_wr,
  input  wire [7:0]  acc_wdata,
  output wire        acc_rvalid,
  output wire [7:0]  acc_rdata,
  output wire        acc_zero,
  output wire        mem_en,
  output wire        mem_we,
  output wire [7:0]  mem_addr,
  output wire [7:0]  mem_bank,
  output wire [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  input  wire        tbl_rd,
  input  wire        tbl_wr,
  output wire        pm_rd,
  output wire        pm_wr,
  output wire [15:0] pm_addr,
  output wire [15:0] pm_wdata,
  input  wire [15:0] pm_rdata,
  input  wire        pm_rvalid,
  output wire        int_pm_ok,
  output wire        cfg_area_ok,
  output wire        fetch_ext,
  output wire        data_onchip
);

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function [7:0] step_ptr;
    input [7:0] p;
    input [1:0] c;
    begin
      if (c[1])
        step_ptr = p;
      else if (c == `IDA_STEP_INC)
        step_ptr = p + 8'h01;
      else
        step_ptr = p - 8'h01;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg        aw_full_q, w_full_q;
  reg [7:0]  awaddr_q;
  reg [7:0]  wbyte_q;
  reg        wstrb0_q;
  reg [1:0]  bresp_q, rresp_q;
  reg [31:0] rdata_q;
  reg [7:0]  bank_q, alu_q, tpl_q, tph_q, tll_q, tlh_q;
  reg [1:0]  mode_q;
  reg        en_q, we_q, rv_q, vrd_q, zero_q, rdv_q;
  reg [7:0]  addr_q, mbank_q, mwd_q, rd_q;
  reg        pm_rd_q, pm_wr_q;
  reg [15:0] pm_addr_q, pm_wd_q;
  reg        ipm_q, cfg_q, fext_q, don_q;
  wire [15:0] ptr_all;

  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_en = do_wr & wstrb0_q;
  wire [7:0] cur_ptr = acc_ch ? ptr_all[15:8] : ptr_all[7:0];
  wire cur_virt = (cur_ptr == `IDA_VA0_ADR) || (cur_ptr == `IDA_VA1_ADR);
  wire cur_bank = (cur_ptr >= `IDA_BANK_LO) || (cur_ptr[7:3] == `IDA_PBANK_HI5);

  // ----------------------------------------
  // Pointer channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      reg [7:0] ptr_q;
      wire [1:0] ctl = alu_q[`IDA_CTL0_LO + 2 * g +: 2];
      wire hit = wr_en && (awaddr_q == (g ? `IDA_A_PTR1 : `IDA_A_PTR0));
      always @(posedge aclk) begin
        if (!aresetn)
          ptr_q <= 8'h00;
        else if (hit)
          ptr_q <= wbyte_q;
        else if (acc_valid && acc_ch == g)
          ptr_q <= step_ptr(ptr_q, ctl);
      end
      assign ptr_all[8 * g +: 8] = ptr_q;
    end
  endgenerate

  // ----------------------------------------
  // Indirect access pipeline
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      we_q <= 1'b0;
      rv_q <= 1'b0;
      vrd_q <= 1'b0;
      addr_q <= 8'h00;
      mbank_q <= 8'h00;
      mwd_q <= 8'h00;
      rdv_q <= 1'b0;
      rd_q <= 8'h00;
      zero_q <= 1'b0;
    end else begin
      en_q <= acc_valid & ~cur_virt;
      we_q <= acc_valid & acc_wr & ~cur_virt;
      rv_q <= acc_valid & ~acc_wr & ~cur_virt;
      vrd_q <= acc_valid & ~acc_wr & cur_virt;
      addr_q <= cur_ptr;
      mbank_q <= cur_bank ? bank_q : 8'h00;
      mwd_q <= acc_wdata;
      rdv_q <= rv_q | vrd_q;
      rd_q <= vrd_q ? 8'h00 : mem_rdata;
      zero_q <= vrd_q;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      bank_q <= 8'h00;
      alu_q <= `IDA_ALU_RST;
      tpl_q <= 8'h00;
      tph_q <= 8'h00;
      tll_q <= 8'h00;
      tlh_q <= 8'h00;
      mode_q <= `IDA_MODE_RST;
    end else begin
      if (wr_en && awaddr_q == `IDA_A_BANK)
        bank_q <= wbyte_q;
      if (wr_en && awaddr_q == `IDA_A_ALU)
        alu_q <= wbyte_q;
      // Hardware set of Z wins over a software clear
      if (vrd_q)
        alu_q[`IDA_Z_BIT] <= 1'b1;
      if (wr_en && awaddr_q == `IDA_A_TPL)
        tpl_q <= wbyte_q;
      if (wr_en && awaddr_q == `IDA_A_TPH)
        tph_q <= wbyte_q;
      if (wr_en && awaddr_q == `IDA_A_TLL)
        tll_q <= wbyte_q;
      if (wr_en && awaddr_q == `IDA_A_TLH)
        tlh_q <= wbyte_q;
      // Program memory answer wins over a software write
      if (pm_rvalid) begin
        tll_q <= pm_rdata[7:0];
        tlh_q <= pm_rdata[15:8];
      end
      if (wr_en && awaddr_q == `IDA_A_MODE)
        mode_q <= wbyte_q[1:0];
    end
  end

  // ----------------------------------------
  // Table transfers and mode decode
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pm_rd_q <= 1'b0;
      pm_wr_q <= 1'b0;
      pm_addr_q <= 16'h0000;
      pm_wd_q <= 16'h0000;
      ipm_q <= 1'b0;
      cfg_q <= 1'b0;
      fext_q <= 1'b1;
      don_q <= 1'b1;
    end else begin
      pm_rd_q <= tbl_rd;
      pm_wr_q <= tbl_wr & ~tbl_rd;
      if (tbl_rd | tbl_wr) begin
        pm_addr_q <= {tph_q, tpl_q};
        pm_wd_q <= {tlh_q, tll_q};
      end
      ipm_q <= (mode_q != `IDA_MODE_MP);
      cfg_q <= (mode_q == `IDA_MODE_MC) || (mode_q == `IDA_MODE_PMC);
      fext_q <= (mode_q == `IDA_MODE_MP) || (mode_q == `IDA_MODE_EMC);
      don_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  wire wr_map = (awaddr_q <= `IDA_A_STAT) && (awaddr_q[1:0] == 2'h0);

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `IDA_RESP_OK;
    end else begin
      if (s_awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_awaddr;
        awready_q <= 1'b0;
      end
      if (s_wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wbyte_q <= s_wdata[7:0];
        wstrb0_q <= s_wstrb[0];
        wready_q <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? `IDA_RESP_OK : `IDA_RESP_ERR;
      end
      if (bvalid_q && s_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  reg [7:0] rd_byte;
  reg       rd_err;
  always @* begin
    rd_err = 1'b0;
    if (s_araddr == `IDA_A_PTR0)
      rd_byte = ptr_all[7:0];
    else if (s_araddr == `IDA_A_PTR1)
      rd_byte = ptr_all[15:8];
    else if (s_araddr == `IDA_A_BANK)
      rd_byte = bank_q;
    else if (s_araddr == `IDA_A_ALU)
      rd_byte = alu_q;
    else if (s_araddr == `IDA_A_TPL)
      rd_byte = tpl_q;
    else if (s_araddr == `IDA_A_TPH)
      rd_byte = tph_q;
    else if (s_araddr == `IDA_A_TLL)
      rd_byte = tll_q;
    else if (s_araddr == `IDA_A_TLH)
      rd_byte = tlh_q;
    else if (s_araddr == `IDA_A_MODE)
      rd_byte = {6'h00, mode_q};
    else if (s_araddr == `IDA_A_STAT)
      rd_byte = {4'h0, don_q, fext_q, cfg_q, ipm_q};
    else begin
      rd_byte = 8'h00;
      rd_err = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `IDA_RESP_OK;
    end else begin
      if (s_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= rd_err ? `IDA_RESP_ERR : `IDA_RESP_OK;
      end
      if (rvalid_q && s_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign {s_awready, s_wready, s_bvalid} = {awready_q, wready_q, bvalid_q};
  assign {s_arready, s_rvalid} = {arready_q, rvalid_q};
  assign {s_bresp, s_rresp, s_rdata} = {bresp_q, rresp_q, rdata_q};
  assign {acc_rvalid, acc_rdata, acc_zero} = {rdv_q, rd_q, zero_q};
  assign {mem_en, mem_we, mem_addr, mem_bank, mem_wdata} = {en_q, we_q, addr_q, mbank_q, mwd_q};
  assign {pm_rd, pm_wr, pm_addr, pm_wdata} = {pm_rd_q, pm_wr_q, pm_addr_q, pm_wd_q};
  assign {int_pm_ok, cfg_area_ok, fetch_ext, data_onchip} = {ipm_q, cfg_q, fext_q, don_q};

endmodule

// ===== rtl/ida_defs.vh
/*
 * Constants for the indirect data addressing block: register offsets,
 * field positions, reset values and encodings.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef IDA_DEFS_VH
`define IDA_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IDA_A_PTR0    8'h00
`define IDA_A_PTR1    8'h04
`define IDA_A_BANK    8'h08
`define IDA_A_ALU     8'h0C
`define IDA_A_TPL     8'h10
`define IDA_A_TPH     8'h14
`define IDA_A_TLL     8'h18
`define IDA_A_TLH     8'h1C
`define IDA_A_MODE    8'h20
`define IDA_A_STAT    8'h24

// ----------------------------------------
// Fields, reset values, encodings
// ----------------------------------------
`define IDA_CTL0_LO   4
`define IDA_CTL1_LO   6
`define IDA_Z_BIT     2
`define IDA_ALU_RST   8'hF0
`define IDA_STEP_DEC  2'h0
`define IDA_STEP_INC  2'h1
`define IDA_VA0_ADR   8'h00
`define IDA_VA1_ADR   8'h08
`define IDA_BANK_LO   8'h20
`define IDA_PBANK_HI5 5'h02
`define IDA_MODE_MP   2'h0
`define IDA_MODE_MC   2'h1
`define IDA_MODE_EMC  2'h2
`define IDA_MODE_PMC  2'h3
`define IDA_MODE_RST  2'h0
`define IDA_RESP_OK   2'h0
`define IDA_RESP_ERR  2'h2

`endif

// ===== sim/ida_mem_model.sv
/* Data memory and program memory beside ida_top.
   Assumes the shared aclk; data read is combinational. */
`timescale 1ns/1ps
module ida_mem_model (
  input  wire logic        aclk,
  input  wire logic        mem_en,
  input  wire logic        mem_we,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  input  wire logic        pm_rd,
  input  wire logic [15:0] pm_addr,
  output logic      [15:0] pm_rdata,
  output logic             pm_rvalid
);
  // ----------------------------------------
  // Storage and answers
  // ----------------------------------------
  logic [7:0]  mem [256];
  logic [15:0] pm_q;
  initial begin
    pm_rvalid = 1'h0;
    pm_q      = 16'h0000;
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3C;
  end
  // Unselected bus shows the inverse, never a stale value
  assign mem_rdata = mem_en ? mem[mem_addr] : ~mem[mem_addr];
  assign pm_rdata  = pm_rvalid ? pm_q : ~pm_q;
  always @(posedge aclk) begin
    if (mem_en && mem_we) mem[mem_addr] <= mem_wdata;
    pm_rvalid <= pm_rd;
    pm_q      <= pm_addr ^ 16'h5A5A;
  end
endmodule

// ===== sim/ida_top_asserts.sv
/* Port checker for ida_top.
   Assumes binding to ida_top, one clock domain. */
`timescale 1ns/1ps
module ida_top_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       acc_valid,
  input wire logic       acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic       acc_rvalid,
  input wire logic [7:0] acc_rdata,
  input wire logic       acc_zero,
  input wire logic       mem_en,
  input wire logic       mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_bank,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic       tbl_rd,
  input wire logic       tbl_wr,
  input wire logic       pm_rd,
  input wire logic       pm_wr,
  input wire logic       int_pm_ok,
  input wire logic       cfg_area_ok,
  input wire logic       fetch_ext,
  input wire logic       data_onchip
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rd_done_a: assert property (acc_valid && !acc_wr |=> ##1 acc_rvalid)
    else $error("read result missing");
  zero_read_a: assert property (acc_zero |-> acc_rvalid && acc_rdata == 8'h00)
    else $error("virtual read not zero");
  mem_data_a: assert property (mem_en && !mem_we |=> acc_rvalid && !acc_zero && acc_rdata == $past(mem_rdata))
    else $error("read data not from memory");
  wr_data_a: assert property (acc_valid && acc_wr |=> !mem_en || (mem_we && mem_wdata == $past(acc_wdata)))
    else $error("write data wrong");
  mem_cause_a: assert property (mem_en |-> $past(acc_valid) && mem_we == $past(acc_wr))
    else $error("memory access without request");
  virt_skip_a: assert property (mem_en |-> mem_addr != 8'h00 && mem_addr != 8'h08)
    else $error("virtual address reached memory");
  unbanked_a: assert property (mem_en && (mem_addr < 8'h10 || mem_addr[7:3] == 5'h03) |-> mem_bank == 8'h00)
    else $error("bank on unbanked address");
  tbl_rd_a: assert property (tbl_rd |=> pm_rd && !pm_wr)
    else $error("table read missing");
  tbl_wr_a: assert property (tbl_wr && !tbl_rd |=> pm_wr && !pm_rd)
    else $error("table write missing");
  mode_map_a: assert property (data_onchip && (int_pm_ok || fetch_ext) && (!cfg_area_ok || (int_pm_ok && !fetch_ext)))
    else $error("mode access map wrong");
  cover property (acc_zero);
  cover property (mem_en && mem_we);
  cover property (tbl_rd ##1 pm_rd);
endmodule
bind ida_top ida_top_asserts chk (.aclk, .aresetn, .acc_valid, .acc_wr, .acc_wdata, .acc_rvalid, .acc_rdata,
  .acc_zero, .mem_en, .mem_we, .mem_addr, .mem_bank, .mem_wdata, .mem_rdata, .tbl_rd, .tbl_wr, .pm_rd, .pm_wr,
  .int_pm_ok, .cfg_area_ok, .fetch_ext, .data_onchip);

// ===== sim/ida_top_tb.sv
/* Self-checking bench for ida_top.
   Assumes ida_mem_model content i^3C and program data addr^5A5A. */
`timescale 1ns/1ps
`include "ida_defs.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module ida_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {logic ch; logic [1:0] ctl; logic [7:0] p; logic [7:0] nx;} ida_row_t;
  logic        aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        acc_valid = 0, acc_ch = 0, acc_wr = 0, tbl_rd = 0, tbl_wr = 0;
  logic [7:0]  s_awaddr = 0, s_araddr = 0, acc_wdata = 0, acc_rdata, mem_addr, mem_bank, mem_wdata, mem_rdata;
  logic [2:0]  s_awprot = 0, s_arprot = 0;
  logic [3:0]  s_wstrb = 4'hF;
  logic [31:0] s_wdata = 0, s_rdata, rd_q;
  logic [1:0]  s_bresp, s_rresp, rr_q;
  logic [15:0] pm_addr, pm_wdata, pm_rdata;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, acc_rvalid, acc_zero, mem_en, mem_we;
  logic        pm_rd, pm_wr, pm_rvalid, int_pm_ok, cfg_area_ok, fetch_ext, data_onchip, a_en, a_rv, a_z;
  logic [7:0]  a_addr, a_bank, a_data;
  int          n_errors = 0, n_compared = 0;
  ida_row_t rows[7] = '{'{1'h0, 2'h1, 8'h30, 8'h31}, '{1'h0, 2'h0, 8'h30, 8'h2F}, '{1'h0, 2'h2, 8'h19, 8'h19},
    '{1'h0, 2'h1, 8'h12, 8'h13}, '{1'h1, 2'h3, 8'h50, 8'h50}, '{1'h1, 2'h1, 8'hFF, 8'h00}, '{1'h1, 2'h0, 8'h21, 8'h20}};
  ida_top dut (.aclk, .aresetn, .s_awaddr, .s_awprot, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arprot, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .acc_valid, .acc_ch, .acc_wr, .acc_wdata, .acc_rvalid, .acc_rdata, .acc_zero, .mem_en,
    .mem_we, .mem_addr, .mem_bank, .mem_wdata, .mem_rdata, .tbl_rd, .tbl_wr, .pm_rd, .pm_wr, .pm_addr, .pm_wdata,
    .pm_rdata, .pm_rvalid, .int_pm_ok, .cfg_area_ok, .fetch_ext, .data_onchip);
  ida_mem_model mdl (.aclk, .mem_en, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .pm_rd, .pm_addr, .pm_rdata,
    .pm_rvalid);
  initial forever #2.5 aclk = ~aclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task report_and_stop;
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task tmo(input int i);
    if (i >= 50) begin n_errors++; report_and_stop; end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    int i;
    @(posedge aclk); s_awaddr <= a; s_wdata <= {24'h0, d}; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 0;
      if (s_wready) s_wvalid <= 0;
      if (s_bvalid) begin s_bready <= 0; rr_q = s_bresp; break; end
    end
    tmo(i);
  endtask
  task rd(input [7:0] a);
    int i;
    @(posedge aclk); s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 0;
      if (s_rvalid) begin s_rready <= 0; rd_q = s_rdata; rr_q = s_rresp; break; end
    end
    tmo(i);
  endtask
  task acc(input c, input w, input [7:0] d);
    @(posedge aclk); acc_valid <= 1; acc_ch <= c; acc_wr <= w; acc_wdata <= d;
    @(posedge aclk); acc_valid <= 0;
    #1 a_en = mem_en; a_addr = mem_addr; a_bank = mem_bank;
    @(posedge aclk);
    #1 a_rv = acc_rvalid; a_z = acc_zero; a_data = acc_rdata;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(8'h0C); `CHK("alu_reset", `IDA_ALU_RST, rd_q[7:0])
    rd(8'h24); `CHK("mode_reset", 8'h0C, rd_q[7:0])
    wr(8'h08, 8'h05);
    foreach (rows[k]) begin
      wr(8'h0C, rows[k].ch ? {rows[k].ctl, 6'h30} : {2'h3, rows[k].ctl, 4'h0});
      wr({5'h0, rows[k].ch, 2'h0}, rows[k].p);
      acc(rows[k].ch, 1'h0, 8'h00);
      `CHK("mem_addr", rows[k].p, a_addr)
      `CHK("mem_bank", (rows[k].p >= 8'h20 || rows[k].p[7:3] == 5'h02) ? 8'h05 : 8'h00, a_bank)
      `CHK("acc_rdata", rows[k].p ^ 8'h3C, a_data)
      rd({5'h0, rows[k].ch, 2'h0}); `CHK("pointer", rows[k].nx, rd_q[7:0])
      rd(8'h0C); `CHK("z_after_step", 1'h0, rd_q[2])
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h20, m[7:0]); `CHK("mode_resp", `IDA_RESP_OK, rr_q)
      rd(8'h24);
      `CHK("mode_map", {4'h0, 1'h1, m == 0 || m == 2, m == 1 || m == 3, m != 0}, rd_q[7:0])
    end
    rd(8'h28); `CHK("unmapped", `IDA_RESP_ERR, rr_q)
    wr(8'h28, 8'h00); `CHK("unmapped_wr", `IDA_RESP_ERR, rr_q)
    s_wstrb <= 4'hE; wr(8'h08, 8'hAA); `CHK("strb_resp", `IDA_RESP_OK, rr_q)
    s_wstrb <= 4'hF; rd(8'h08); `CHK("strb_skip", 8'h05, rd_q[7:0])
    wr(8'h0C, 8'hF0); wr(8'h00, 8'h00); acc(1'h0, 1'h0, 8'h00);
    `CHK("virt_rd", 11'h300, {a_en, a_rv, a_z, a_data})
    rd(8'h0C); `CHK("z_set", 1'h1, rd_q[2])
    wr(8'h0C, 8'hF0); wr(8'h04, 8'h08); acc(1'h1, 1'h1, 8'hAA);
    `CHK("virt_wr", 1'h0, a_en)
    rd(8'h0C); `CHK("virt_wr_alu", 8'hF0, rd_q[7:0])
    wr(8'h0C, 8'hD0); wr(8'h00, 8'h40);
    @(posedge aclk); acc_valid <= 1; acc_ch <= 0; acc_wr <= 1; acc_wdata <= 8'h11;
    @(posedge aclk); acc_wdata <= 8'h22;
    @(posedge aclk); acc_valid <= 0;
    wr(8'h00, 8'h40); acc(1'h0, 1'h0, 8'h00); `CHK("b2b_first", 8'h11, a_data)
    acc(1'h0, 1'h0, 8'h00); `CHK("b2b_second", 8'h22, a_data)
    wr(8'h10, 8'h34); wr(8'h14, 8'h12);
    @(posedge aclk); tbl_rd <= 1;
    @(posedge aclk); tbl_rd <= 0;
    #1 `CHK("pm_addr", 16'h1234, pm_addr)
    repeat (3) @(posedge aclk);
    rd(8'h18); `CHK("latch_low", 8'h6E, rd_q[7:0])
    rd(8'h1C); `CHK("latch_high", 8'h48, rd_q[7:0])
    wr(8'h18, 8'hCD); wr(8'h1C, 8'hAB);
    @(posedge aclk); tbl_wr <= 1;
    @(posedge aclk); tbl_wr <= 0;
    #1 `CHK("pm_wdata", 16'hABCD, pm_wdata)
    @(posedge aclk); aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00); `CHK("ptr_reset", 8'h00, rd_q[7:0])
    rd(8'h18); `CHK("latch_reset", 8'h00, rd_q[7:0])
    rd(8'h24); `CHK("mode_reset2", 8'h0C, rd_q[7:0])
    report_and_stop;
  end
endmodule
